// >>> src/anp_autoneg.sv
`timescale 1ns/10ps
`include "anp_defines.svh"
// Notes on behaviour
// RULE1: No FLP answer leads to parallel detection.
// RULE2: NLP or idles clear partner-capable bit.
// RULE3: Parallel detect sets 10 or 100 ability.
// RULE4: Parallel detected partners get half duplex.
// RULE5: Parallel detect sets complete, enables technology.
// RULE6: NLP means 10 only; idles mean 100.
// RULE7: FLP answer sets partner-capable bit.
// RULE8: No receive energy sets no-signal bit.
// RULE9: Several indications: fault, nothing enabled.
// RULE10: Partner remote fault sets three status bits.
// RULE11: Fault during exchange also sets extended bit.
// RULE12: Local fault is sent and recorded.
// RULE13: Negotiation runs at power-up and on request.
// RULE14: Any reset idles machines, clears progress.
// RULE15: Restart idles machines, keeps progress bits.
// RULE16: Progress changes only by read, reset, climb.
// RULE17: Progress updates only to higher values.
// RULE18: After completion only read or reset.
// RULE19: Link failure or restart bit restarts; the code takes the restart bit only in software mode (config_source_pin high).
// RULE20: Software mode enable toggle restarts.
// RULE21: Hardware mode select pin toggle restarts.
// RULE22: Read returns held value, latches present.
module anp_autoneg #(
  parameter int unsigned WAIT_CYCLES = `ANP_WAIT_NS / `ANP_CLK_NS
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register bus.
  input wire anp_pkg::anp_av_req_type av_req,
  output anp_pkg::anp_av_rsp_type av_rsp,
  // Line side and mode pins.
  input wire anp_pkg::anp_line_type line,
  input wire logic config_source_pin,
  input wire logic negotiation_select_pin,
  // Technology control.
  output logic en_10,
  output logic en_100,
  output logic full_duplex,
  output logic tx_remote_fault
);
  import anp_pkg::*;

  anp_regs_type q;       // Registered state.
  anp_regs_type next_q;  // Next state.
  logic en_now;          // Effective negotiation enable.
  logic restart;         // Restart request this cycle.
  logic soft_rst;        // Software reset this cycle.
  logic pm_read;         // Detailed status read accepted.
  logic [3:0] cur_pm;    // Progress code of the present state.
  logic [1:0] n_ind;     // Count of technology indications.
  logic [5:0] idx;       // Register index of the request.

  assign idx = av_req.address[7:2];
  assign n_ind = 2'(line.flp) + 2'(line.nlp) + 2'(line.idle100);
  // Software mode takes the enable bit, hardware mode the select pin.
  assign en_now = config_source_pin ? q.ctrl_en : negotiation_select_pin;
  // The complete state shows the complete bit with a zero code.
  assign cur_pm = (q.st == AS_COMPLETE) ? `ANP_PM_DONE_NOW : {1'b0, q.st};

  // Outputs come straight from the state flops.
  assign av_rsp.readdata = q.rdata;
  assign av_rsp.waitrequest = q.wait_q;
  assign en_10 = q.en10;
  assign en_100 = q.en100;
  assign full_duplex = q.fdx;
  assign tx_remote_fault = q.tx_rf;

  // Value of every flop after any reset.
  function automatic anp_regs_type rst_val();
    anp_regs_type r;
    r = '0;
    r.st = AS_IDLE;
    r.ctrl_en = `ANP_CTRL_EN_RST;
    r.wait_q = 1'b1;
    return r;
  endfunction

  // Read data for a register index; unmapped ones read zero.
  function automatic logic [31:0] rd_mux(anp_regs_type s, logic [5:0] i, logic lk);
    logic [31:0] d;
    d = 32'h0;
    case (i)
      `ANP_IDX_CTRL: begin
        d[`ANP_CTRL_EN] = s.ctrl_en;
      end
      `ANP_IDX_STAT: begin
        d[`ANP_STAT_DONE] = s.complete;
        d[`ANP_STAT_RFLT] = s.st_rf;
      end
      `ANP_IDX_LPAB: begin
        d[`ANP_LPAB_RFLT] = s.lp_rf;
        d[`ANP_LPAB_100HD] = s.lp100;
        d[`ANP_LPAB_10HD] = s.lp10;
      end
      `ANP_IDX_EXPN: begin
        d[`ANP_EXPN_PDFLT] = s.pd_fault;
        d[`ANP_EXPN_LPCAP] = s.lp_cap;
      end
      `ANP_IDX_DSTAT: begin
        // The held progress value is shown, not the present one.
        d[`ANP_DS_RATE] = s.en100;
        d[`ANP_DS_DPLX] = s.fdx;
        d[`ANP_DS_PM_HI:`ANP_DS_PM_LO] = s.pm[2:0]; // [RULE22]
        d[`ANP_DS_DONE] = s.pm[3];
        d[`ANP_DS_NOSIG] = s.nosig;
        d[`ANP_DS_RFLT] = s.st_rf;
        d[`ANP_DS_LINK] = lk;
      end
      `ANP_IDX_XCTL: begin
        d[`ANP_XCTL_RFLT] = s.xc_rf;
      end
      default: begin
        d = 32'h0;
      end
    endcase
    return d;
  endfunction

  // Next-state logic for bus, arbitration, faults and progress.
  always_comb begin
    next_q = q;
    restart = 1'b0;
    soft_rst = 1'b0;
    pm_read = 1'b0;
    next_q.en_q = en_now;
    next_q.link_q = line.link_up;
    next_q.tx_rf = line.local_fault;
    // Bus slave: one wait cycle, then acceptance with waitrequest low.
    if (q.wait_q) begin
      if (av_req.read || av_req.write) begin
        next_q.wait_q = 1'b0;
        next_q.rdata = rd_mux(q, idx, line.link_up);
      end
    end else begin
      next_q.wait_q = 1'b1;
      if (av_req.write && idx == `ANP_IDX_CTRL) begin
        next_q.ctrl_en = av_req.writedata[`ANP_CTRL_EN];
        soft_rst = av_req.writedata[`ANP_CTRL_SRST];
        // The restart bit is never stored, so it reads back as zero.
        restart = av_req.writedata[`ANP_CTRL_RESTART] & config_source_pin; // [RULE19]
      end
      pm_read = av_req.read && idx == `ANP_IDX_DSTAT;
    end
    // Arbitration state machine.
    case (q.st)
      AS_IDLE: begin
        // Leave idle as soon as negotiation is enabled.
        if (en_now) begin
          next_q.st = AS_ABILITY; // [RULE13]
          next_q.timer = 32'h0;
        end
      end
      AS_ABILITY: begin
        next_q.timer = 32'(q.timer + 32'h1);
        if (line.energy) begin
          next_q.nosig = 1'b0;
        end
        if (n_ind > 2'h1) begin
          // Mixed indications: flag it and enable nothing.
          next_q.pd_fault = 1'b1; // [RULE9]
          next_q.en10 = 1'b0;
          next_q.en100 = 1'b0;
        end else if (line.flp) begin
          // Partner answers with FLP bursts.
          next_q.lp_cap = 1'b1; // [RULE7]
          next_q.st = AS_ACK;
        end else if (line.nlp || line.idle100) begin
          // No FLP answer: classify the partner by what it sends.
          next_q.lp_cap = 1'b0; // [RULE1] [RULE2]
          next_q.lp10 = line.nlp; // [RULE3] [RULE6]
          next_q.lp100 = line.idle100;
          next_q.st = AS_PARALLEL;
        end else if (q.timer >= 32'(WAIT_CYCLES - 1)) begin
          // A whole wait with no energy marks the line as silent.
          next_q.timer = 32'h0;
          next_q.nosig = ~line.energy; // [RULE8]
        end
      end
      AS_ACK: begin
        // Exchange finished; take the resolved technology.
        if (line.cx_done) begin
          next_q.st = AS_COMPLETE;
          next_q.complete = 1'b1;
          next_q.en100 = line.cx_100;
          next_q.en10 = ~line.cx_100;
          next_q.fdx = line.cx_full;
        end
      end
      AS_PARALLEL: begin
        // Parallel detection ends in half duplex only.
        next_q.st = AS_COMPLETE;
        next_q.complete = 1'b1; // [RULE5]
        next_q.en10 = q.lp10;
        next_q.en100 = q.lp100;
        next_q.fdx = 1'b0; // [RULE4]
      end
      AS_COMPLETE: begin
        next_q.st = AS_COMPLETE;
      end
      default: begin
        next_q.st = AS_IDLE;
      end
    endcase
    // Disabling negotiation parks the machine.
    if (!en_now) begin
      next_q.st = AS_IDLE;
    end
    // Link failure and enable toggles restart the machine.
    if (q.st == AS_COMPLETE && q.link_q && !line.link_up) begin
      restart = 1'b1; // [RULE19]
    end
    if (en_now && !q.en_q) begin
      restart = 1'b1; // [RULE20] [RULE21]
    end
    // Restart clears results but keeps the progress bits.
    if (restart) begin
      next_q.st = AS_IDLE; // [RULE15]
      next_q.timer = 32'h0;
      next_q.complete = 1'b0;
      next_q.en10 = 1'b0;
      next_q.en100 = 1'b0;
      next_q.fdx = 1'b0;
      next_q.lp10 = 1'b0;
      next_q.lp100 = 1'b0;
    end
    // Fault sets come after the restart clears, so a restart never loses a set; a software reset still clears it.
    if (line.rx_rfault) begin
      next_q.st_rf = 1'b1; // [RULE10]
      next_q.lp_rf = 1'b1;
      if (q.st == AS_ABILITY || q.st == AS_ACK) begin
        next_q.xc_rf = 1'b1; // [RULE11]
      end
    end
    if (line.local_fault) begin
      next_q.lp_rf = 1'b1; // [RULE12]
      next_q.xc_rf = 1'b1;
    end
    // Progress monitor climbs only upward and freezes at completion.
    if (q.st != AS_COMPLETE && cur_pm > q.pm) begin
      next_q.pm = cur_pm; // [RULE16] [RULE17]
    end
    if (q.st != AS_COMPLETE && next_q.st == AS_COMPLETE) begin
      next_q.pm = `ANP_PM_DONE_HELD; // [RULE18]
    end
    // A read latches the present state whatever its value.
    if (pm_read) begin
      next_q.pm = cur_pm; // [RULE22]
    end
    // Software reset acts like the pin reset.
    if (soft_rst) begin
      next_q = rst_val(); // [RULE14]
    end
  end

  // State register; the clock enable freezes everything except the pin reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= rst_val(); // [RULE14]
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // Every check below runs on the rising clock and sleeps while reset is low.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_pd_clears_cap: assert property ( // [RULE1] [RULE2]
    clk_en && q.st == AS_ABILITY && n_ind == 2'h1 && !line.flp && !restart && !soft_rst
    && en_now |=> q.st == AS_PARALLEL && !q.lp_cap)
    else $error("parallel detection did not clear partner capable");
  a_pd_one_tech: assert property ( // [RULE3] [RULE6]
    q.st == AS_PARALLEL |-> (q.lp10 ^ q.lp100))
    else $error("parallel detection without exactly one technology");
  a_pd_half_dup: assert property ( // [RULE4] [RULE5]
    clk_en && q.st == AS_PARALLEL && en_now && !restart && !soft_rst
    |=> q.complete && !q.fdx && q.en10 == $past(q.lp10) && q.en100 == $past(q.lp100))
    else $error("parallel detection did not complete in half duplex");
  a_flp_cap_set: assert property ( // [RULE7]
    clk_en && q.st == AS_ABILITY && line.flp && n_ind == 2'h1 && !soft_rst |=> q.lp_cap)
    else $error("FLP answer did not set partner capable");
  a_nosig_set: assert property ( // [RULE8]
    clk_en && q.st == AS_ABILITY && n_ind == 2'h0 && !line.energy
    && q.timer >= 32'(WAIT_CYCLES - 1) && !soft_rst |=> q.nosig)
    else $error("silent line not flagged");
  a_multi_fault: assert property ( // [RULE9]
    clk_en && q.st == AS_ABILITY && n_ind > 2'h1 && !soft_rst
    |=> q.pd_fault && !q.en10 && !q.en100)
    else $error("mixed indications not flagged");
  a_rx_rfault: assert property ( // [RULE10] [RULE11]
    clk_en && line.rx_rfault && q.st == AS_ABILITY && !soft_rst
    |=> q.st_rf && q.lp_rf && q.xc_rf)
    else $error("remote fault bits not set");
  a_local_fault: assert property ( // [RULE12]
    clk_en && line.local_fault && !soft_rst |=> q.tx_rf && q.lp_rf && q.xc_rf)
    else $error("local fault not sent or recorded");
  a_reset_clears: assert property ( // [RULE14]
    clk_en && soft_rst |=> q.st == AS_IDLE && q.pm == 4'h0)
    else $error("reset did not clear progress");
  a_restart_idle: assert property ( // [RULE15] [RULE19] [RULE20] [RULE21]
    clk_en && restart && !soft_rst && !pm_read |=> q.st == AS_IDLE && q.pm >= $past(q.pm))
    else $error("restart did not idle or lost progress");
  a_pm_upward: assert property ( // [RULE16] [RULE17]
    clk_en && !pm_read && !soft_rst |=> q.pm >= $past(q.pm))
    else $error("progress fell without a read");
  a_pm_frozen: assert property ( // [RULE18]
    clk_en && q.st == AS_COMPLETE && !pm_read && !soft_rst |=> $stable(q.pm))
    else $error("progress changed after completion");
  a_read_latch: assert property ( // [RULE22]
    clk_en && pm_read && !soft_rst |=> q.pm == $past(cur_pm))
    else $error("read did not latch present state");

  // Each restart path idles the machine, and an enabled idle machine starts at once.
  a_link_restart: assert property ( // [RULE19]
    clk_en && q.st == AS_COMPLETE && q.link_q && !line.link_up && !soft_rst
    |=> q.st == AS_IDLE && !q.complete)
    else $error("link failure did not restart");
  a_restart_bit: assert property ( // [RULE19]
    clk_en && !q.wait_q && av_req.write && idx == `ANP_IDX_CTRL && config_source_pin
    && av_req.writedata[`ANP_CTRL_RESTART] && !av_req.writedata[`ANP_CTRL_SRST]
    |=> q.st == AS_IDLE && !q.complete)
    else $error("restart bit did not restart");
  a_enable_rise: assert property ( // [RULE20] [RULE21]
    clk_en && en_now && !q.en_q && !soft_rst |=> q.st == AS_IDLE && !q.complete)
    else $error("enable toggle did not restart");
  a_power_up: assert property ( // [RULE13]
    clk_en && q.st == AS_IDLE && en_now && !restart && !soft_rst |=> q.st == AS_ABILITY)
    else $error("negotiation did not start");

  // Main scenarios that the bench is expected to reach.
  c_parallel: cover property (q.st == AS_PARALLEL ##1 q.st == AS_COMPLETE);
  c_exchange: cover property (q.st == AS_ACK ##1 q.st == AS_COMPLETE);
  c_pm_read: cover property (pm_read ##[1:4] pm_read);
  c_restart: cover property (q.st == AS_COMPLETE ##1 restart);
  c_freeze: cover property (!clk_en ##1 clk_en);
endmodule

// >>> shared/anp_defines.svh
`ifndef ANP_DEFINES_SVH
`define ANP_DEFINES_SVH
// Register indices; byte address is four times the index.
`define ANP_IDX_CTRL 6'h00
`define ANP_IDX_STAT 6'h01
`define ANP_IDX_LPAB 6'h05
`define ANP_IDX_EXPN 6'h06
`define ANP_IDX_DSTAT 6'h11
`define ANP_IDX_XCTL 6'h13
// Control register fields.
`define ANP_CTRL_SRST 15
`define ANP_CTRL_EN 12
`define ANP_CTRL_RESTART 9
`define ANP_CTRL_EN_RST 1'b1
// Status register fields.
`define ANP_STAT_DONE 5
`define ANP_STAT_RFLT 4
// Partner ability fields.
`define ANP_LPAB_RFLT 13
`define ANP_LPAB_100HD 7
`define ANP_LPAB_10HD 5
// Expansion fields.
`define ANP_EXPN_PDFLT 4
`define ANP_EXPN_LPCAP 0
// Detailed status fields.
`define ANP_DS_RATE 15
`define ANP_DS_DPLX 14
`define ANP_DS_PM_HI 13
`define ANP_DS_PM_LO 11
`define ANP_DS_DONE 4
`define ANP_DS_NOSIG 3
`define ANP_DS_RFLT 1
`define ANP_DS_LINK 0
// Extended control field.
`define ANP_XCTL_RFLT 13
// Progress codes for the complete state.
`define ANP_PM_DONE_HELD 4'hf
`define ANP_PM_DONE_NOW 4'h8
// Timing.
`define ANP_CLK_NS 4
`define ANP_WAIT_NS 1000000
`endif

// >>> shared/anp_pkg.sv
package anp_pkg;
  // Arbitration states; the order is the progress value, except AS_COMPLETE, which shows the complete bit.
  typedef enum logic [2:0] {
    AS_IDLE,
    AS_ABILITY,
    AS_ACK,
    AS_PARALLEL,
    AS_COMPLETE
  } anp_state_type;
  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } anp_av_req_type;
  // Avalon-MM answer to the master.
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } anp_av_rsp_type;
  // Line indications from the receive side and link monitor.
  typedef struct packed {
    logic flp;
    logic nlp;
    logic idle100;
    logic energy;
    logic rx_rfault;
    logic local_fault;
    logic link_up;
    logic cx_done;
    logic cx_100;
    logic cx_full;
  } anp_line_type;
  // Whole block state.
  typedef struct packed {
    anp_state_type st;
    logic [31:0] timer;
    logic ctrl_en;
    logic en_q;
    logic link_q;
    logic lp_cap;
    logic pd_fault;
    logic lp10;
    logic lp100;
    logic complete;
    logic st_rf;
    logic lp_rf;
    logic xc_rf;
    logic nosig;
    logic [3:0] pm;
    logic en10;
    logic en100;
    logic fdx;
    logic tx_rf;
    logic wait_q;
    logic [31:0] rdata;
  } anp_regs_type;
endpackage

// >>> tb/anp_partner.sv
`timescale 1ns/10ps
// Remote link partner: sends the line traffic chosen by the bench, one kind or pulses and idles together.
module anp_partner (
  // Clock and traffic choice: 0 quiet, 1 pulses, 2 idles, 3 bursts, 4 pulses and idles.
  input wire logic clk,
  input wire logic [2:0] mode,
  input wire logic fault,
  // Indications seen by the block.
  output logic flp,
  output logic nlp,
  output logic idle100,
  output logic energy,
  output logic rx_rfault
);
  // Traffic follows the mode; a fault rides only inside bursts.
  always_ff @(posedge clk) begin
    flp <= (mode == 3'h3);
    nlp <= (mode == 3'h1) || (mode == 3'h4);
    idle100 <= (mode == 3'h2) || (mode == 3'h4);
    energy <= (mode != 3'h0);
    rx_rfault <= fault && (mode == 3'h3);
  end
endmodule

// >>> tb/anp_autoneg_tb.sv
`timescale 1ns/10ps
// Bench: drives the register bus and the line, judges status and enables.
module anp_autoneg_tb;
  import anp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  anp_av_req_type req = '0;
  anp_av_rsp_type rsp;
  anp_line_type line;
  logic [2:0] mode = 3'h0;
  logic rf = 1'b0, lf = 1'b0, cfg = 1'b1, nsel = 1'b1;
  logic lk = 1'b1, ce = 1'b1, cxd = 1'b0, cxf = 1'b0;
  logic flp, nlp, idle, nrg, rrf, en10, en100, fdx, txrf;
  logic [31:0] rd;
  int mismatches = 0;
  int tests_run = 0;
  // Link state and the exchange result come from the bench; speed and duplex move together.
  assign line = '{flp, nlp, idle, nrg, rrf, lf, lk, cxd, cxf, cxf};
  // Clock of 4 ns period.
  always #2 clk = ~clk;
  anp_autoneg #(.WAIT_CYCLES(8)) i_dut (.clk(clk), .nrst(nrst), .clk_en(ce),
    .av_req(req), .av_rsp(rsp), .line(line), .config_source_pin(cfg),
    .negotiation_select_pin(nsel), .en_10(en10), .en_100(en100),
    .full_duplex(fdx), .tx_remote_fault(txrf));
  anp_partner i_lp (.clk(clk), .mode(mode), .fault(rf), .flp(flp), .nlp(nlp),
    .idle100(idle), .energy(nrg), .rx_rfault(rrf));
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  // One Avalon transfer; request held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{~wr, wr, a, d};
    @(posedge clk);
    for (n = 0; n < 20 && rsp.waitrequest !== 1'b0; n++) @(posedge clk);
    if (n == 20) begin
      mismatches++;
      $display("MISMATCH t=%0t bus answer timed out", $time);
      close_out();
    end
    rd = rsp.readdata;
    req <= '0;
  endtask
  // Reads a register and compares the masked bits.
  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
    input string m);
    bus(1'b0, a, 32'h0);
    chk(rd & mk, e, m);
  endtask
  // Waits, bounded, until some technology is enabled.
  task automatic wait_en();
    int n;
    for (n = 0; n < 60 && en10 !== 1'b1 && en100 !== 1'b1; n++) @(posedge clk);
    if (n == 60) begin
      mismatches++;
      $display("MISMATCH t=%0t no technology enabled in time", $time);
      close_out();
    end
  endtask
  // Reset values, unmapped place and the quiet-line flag.
  task automatic t_reset();
    rdc(8'h00, 32'hffff, 32'h1000, "control after reset");
    rdc(8'h08, 32'hffffffff, 32'h0, "unmapped read");
    repeat (16) @(posedge clk);
    rdc(8'h44, 32'h0008, 32'h0008, "no signal flag");
    $display("test reset done");
  endtask
  // Pulse-only partner is parallel detected at 10 half duplex.
  task automatic t_par10();
    ce <= 1'b0;
    mode <= 3'h1;
    repeat (6) @(posedge clk);
    chk(en10, 1'b0, "frozen by clock enable");
    ce <= 1'b1;
    wait_en();
    chk({en10, en100, fdx}, 3'b100, "10 enables");
    rdc(8'h14, 32'h00a0, 32'h0020, "10 ability bit");
    rdc(8'h18, 32'h0001, 32'h0, "partner not capable");
    rdc(8'h04, 32'h0020, 32'h0020, "complete bit");
    rdc(8'h44, 32'h3810, 32'h3810, "held progress");
    rdc(8'h44, 32'h3810, 32'h0010, "present progress");
    $display("test par10 done");
  endtask
  // Restart bit clears completion, keeps progress, clears itself.
  task automatic t_restart();
    mode <= 3'h0;
    bus(1'b1, 8'h00, 32'h1200);
    rdc(8'h04, 32'h0020, 32'h0, "complete cleared");
    chk(en10, 1'b0, "10 disabled by restart");
    rdc(8'h00, 32'hffff, 32'h1000, "restart bit clears");
    rdc(8'h44, 32'h3810, 32'h0010, "progress kept");
    $display("test restart done");
  endtask
  // Idle-only partner is parallel detected at 100 half duplex.
  task automatic t_par100();
    mode <= 3'h2;
    wait_en();
    chk({en10, en100, fdx}, 3'b010, "100 enables");
    rdc(8'h14, 32'h00a0, 32'h0080, "100 ability bit");
    lk <= 1'b0;
    repeat (2) @(posedge clk);
    chk(en100, 1'b0, "link failure restarts");
    rdc(8'h44, 32'h0001, 32'h0, "link bit low");
    lk <= 1'b1;
    wait_en();
    chk(en100, 1'b1, "100 detected again");
    $display("test par100 done");
  endtask
  // Hardware mode select toggle restarts, then both kinds at once fault.
  task automatic t_hw_multi();
    mode <= 3'h0;
    cfg <= 1'b0;
    @(posedge clk);
    nsel <= 1'b0;
    repeat (4) @(posedge clk);
    nsel <= 1'b1;
    rdc(8'h04, 32'h0020, 32'h0, "hw restart");
    chk(en100, 1'b0, "100 off after hw restart");
    cfg <= 1'b1;
    mode <= 3'h4;
    repeat (2) @(posedge clk);
    rdc(8'h18, 32'h0010, 32'h0010, "pd fault");
    chk({en10, en100}, 2'b00, "nothing enabled");
    $display("test hw multi done");
  endtask
  // Enable toggle restarts; bursts with faults both ways.
  task automatic t_fault();
    mode <= 3'h0;
    bus(1'b1, 8'h00, 32'h0000);
    bus(1'b1, 8'h00, 32'h1000);
    rf <= 1'b1;
    lf <= 1'b1;
    mode <= 3'h3;
    repeat (3) @(posedge clk);
    rdc(8'h18, 32'h0001, 32'h0001, "partner capable");
    chk(txrf, 1'b1, "fault sent");
    rdc(8'h04, 32'h0010, 32'h0010, "status fault");
    rdc(8'h14, 32'h2000, 32'h2000, "ability fault");
    rdc(8'h44, 32'h0002, 32'h0002, "detail fault");
    rdc(8'h4c, 32'h2000, 32'h2000, "extended fault");
    cxd <= 1'b1;
    cxf <= 1'b1;
    wait_en();
    chk({en10, en100, fdx}, 3'b011, "exchange result taken");
    $display("test fault done");
  endtask
  // Software reset returns every sticky bit to its reset value.
  task automatic t_srst();
    rf <= 1'b0;
    lf <= 1'b0;
    cxd <= 1'b0;
    cxf <= 1'b0;
    mode <= 3'h0;
    repeat (3) @(posedge clk);
    bus(1'b1, 8'h00, 32'h8000);
    rdc(8'h00, 32'hffff, 32'h1000, "control after soft reset");
    chk({en100, fdx}, 2'b00, "technology cleared");
    rdc(8'h14, 32'hffff, 32'h0, "ability cleared");
    rdc(8'h04, 32'h0030, 32'h0, "status cleared");
    $display("test srst done");
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_par10();
    t_restart();
    t_par100();
    t_hw_multi();
    t_fault();
    t_srst();
    close_out();
  end
endmodule
